// ### pbts_defines.svh
`ifndef PBTS_DEFINES_SVH
`define PBTS_DEFINES_SVH
// Sizes
`define PBTS_NPORT 26
`define PBTS_NSLOT 3
`define PBTS_NENT 78
`define PBTS_MAC_W 48
`define PBTS_DROP_W 16
`define PBTS_GRP_N 3
`define PBTS_GRP_W 4
`define PBTS_FW_W 7
`define PBTS_MIN_MEMBERS 3'h2
// Group base ports, zero based
`define PBTS_G0_BASE 5'h00
`define PBTS_G1_BASE 5'h04
`define PBTS_G2_BASE 5'h18
// Register byte addresses
`define PBTS_A_CTRL 6'h00
`define PBTS_A_BIND 6'h04
`define PBTS_A_TMEM 6'h08
`define PBTS_A_TTYPE 6'h0c
`define PBTS_A_AGREE 6'h10
`define PBTS_A_LINK 6'h14
`define PBTS_A_ACTIVE 6'h18
`define PBTS_A_DROP 6'h1c
`define PBTS_A_MSEL 6'h20
`define PBTS_A_MLO 6'h24
`define PBTS_A_MHI 6'h28
// Field positions
`define PBTS_SLOT_LSB 8
`define PBTS_VLD_BIT 16
`define PBTS_VALID_LSB 12
// Reset value and saturation limit
`define PBTS_RST_WAIT 1'b1
`define PBTS_DROP_MAX 16'hffff
`endif

// ### pbts_pkg.sv
`include "pbts_defines.svh"
package pbts_pkg;
  // Trunk hash input selection
  typedef enum logic [1:0] {
    PBTS_HASH_PORT = 2'h0,
    PBTS_HASH_SA = 2'h1,
    PBTS_HASH_DA = 2'h2,
    PBTS_HASH_SADA = 2'h3
  } pbts_hash_t;
  // Whole state of the top module
  typedef struct packed {
    logic [31:0] rdata;
    logic wait_r;
    pbts_hash_t hsel;
    logic [`PBTS_NPORT-1:0] bind_en;
    logic [11:0] members;
    logic [2:0] neg;
    logic [`PBTS_NPORT-1:0] agree;
    logic [4:0] sel_port;
    logic [1:0] sel_slot;
    logic [`PBTS_NENT-1:0][`PBTS_MAC_W:0] mac;
    logic [`PBTS_NPORT-1:0] sync1;
    logic [`PBTS_NPORT-1:0] sync2;
    logic [`PBTS_NPORT-1:0] sync3;
    logic [`PBTS_NPORT-1:0] link;
    logic [`PBTS_DROP_W-1:0] drop_cnt;
  } pbts_state_t;
endpackage

// ### pbts_hash.sv
`timescale 1ns/100ps
`default_nettype none
module pbts_hash (
  input wire pbts_pkg::pbts_hash_t sel_i,
  input wire logic [4:0] port_i,
  input wire logic [47:0] sa_i,
  input wire logic [47:0] da_i,
  output logic [7:0] hash_o
);
  logic [47:0] key; // Selected hash key
  // Key selection and byte fold
  always_comb
  begin
    unique case (sel_i)
      pbts_pkg::PBTS_HASH_PORT: key = {43'h0, port_i};
      pbts_pkg::PBTS_HASH_SA: key = sa_i;
      pbts_pkg::PBTS_HASH_DA: key = da_i;
      pbts_pkg::PBTS_HASH_SADA: key = sa_i ^ da_i;
    endcase
    hash_o = 8'h00;
    // Pure function of the key, so equal input maps alike
    for (int i = 0; i < 6; i++)
    begin
      hash_o = hash_o ^ key[8*i +: 8];
    end
  end
endmodule
`default_nettype wire

// ### pbts_buf2.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbts_defines.svh"
module pbts_buf2 #(
  parameter int W = `PBTS_FW_W
) (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  // Head drives the output, skid catches a word during a stall
  typedef struct packed {
    logic [W-1:0] head;
    logic head_v;
    logic [W-1:0] skid;
    logic skid_v;
    logic rdy;
  } pbts_buf_state_t;
  pbts_buf_state_t s_q; // Registered state
  pbts_buf_state_t s_d; // Next state
  // Pop, refill from skid, then push
  always_comb
  begin
    s_d = s_q;
    if (s_q.head_v && out_ready_i)
    begin
      s_d.head_v = 1'b0;
    end
    if (!s_d.head_v && s_q.skid_v)
    begin
      s_d.head = s_q.skid;
      s_d.head_v = 1'b1;
      s_d.skid_v = 1'b0;
    end
    if (in_valid_i && s_q.rdy)
    begin
      if (!s_d.head_v)
      begin
        s_d.head = in_data_i;
        s_d.head_v = 1'b1;
      end
      else
      begin
        s_d.skid = in_data_i;
        s_d.skid_v = 1'b1;
      end
    end
    s_d.rdy = !s_d.skid_v;
  end
  // State register
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
      s_q.rdy <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign in_ready_o = s_q.rdy;
  assign out_valid_o = s_q.head_v;
  assign out_data_o = s_q.head;
endmodule
`default_nettype wire

// ### pbts_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbts_defines.svh"
module pbts_top (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic [5:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [`PBTS_NPORT-1:0] link_up_i,
  input wire logic fr_valid_i,
  output logic fr_ready_o,
  input wire logic [4:0] fr_src_port_i,
  input wire logic [4:0] fr_dst_port_i,
  input wire logic [47:0] fr_sa_i,
  input wire logic [47:0] fr_da_i,
  output logic fw_valid_o,
  input wire logic fw_ready_i,
  output logic fw_drop_o,
  output logic fw_trunk_o,
  output logic [4:0] fw_egress_o
);
  ////////////////////////////////////////////////////////////////////
  // Declarations
  pbts_pkg::pbts_state_t s_q; // Registered state
  pbts_pkg::pbts_state_t s_d; // Next state
  logic req_c; // Bus request present
  logic [31:0] rd_c; // Read view of addressed register
  logic [31:0] m_c; // Register merged with write data
  logic [6:0] sel_idx_c; // Table entry chosen by selector
  logic sel_ok_c; // Selector points at a real entry
  logic [6:0] src_idx_c; // First entry of ingress port
  logic src_ok_c; // Ingress port exists
  logic [2:0] match_c; // Per slot source match
  logic bind_on_c; // Binding active on ingress port
  logic drop_c; // Frame to be dropped
  logic [7:0] hash_c; // Hash of selected fields
  logic [27:0] lnk_c; // Link state padded to group width
  logic [27:0] agr_c; // Agreement padded to group width
  logic [2:0] valid_c; // Group has two or more members
  logic [2:0] inr_c; // Destination is a configured member
  logic [2:0] hit_c; // Destination is in a valid group
  logic [2:0][3:0] act_c; // Members usable for traffic
  logic [2:0][4:0] pk_c; // Link picked inside each group
  logic [4:0] egress_c; // Final egress port
  logic trunk_c; // Egress came from a trunk
  logic push_c; // Frame taken into buffer
  logic [`PBTS_FW_W-1:0] fw_data; // Buffer output word

  ////////////////////////////////////////////////////////////////////
  // Helpers
  // Byte-enable merge of write data into old value
  function automatic logic [31:0] pbts_merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] be
  );
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Pick the n-th usable member, n = hash mod count
  function automatic logic [1:0] pbts_pick(
    input logic [3:0] act,
    input logic [7:0] h
  );
    logic [2:0] n;
    logic [2:0] k;
    logic [2:0] c;
    logic [1:0] r;
    n = 3'(act[0]) + 3'(act[1]) + 3'(act[2]) + 3'(act[3]);
    k = (n == 3'h0) ? 3'h0 : 3'(h % 8'(n));
    c = 3'h0;
    r = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (act[i])
      begin
        if (c == k)
        begin
          r = 2'(i);
        end
        c = c + 3'h1;
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Register read view and write merge
  assign req_c = avs_read_i | avs_write_i;
  assign sel_idx_c = 7'(s_q.sel_port) * 7'(`PBTS_NSLOT) + 7'(s_q.sel_slot);
  assign sel_ok_c = (s_q.sel_port < 5'(`PBTS_NPORT)) &&
                    (s_q.sel_slot < 2'(`PBTS_NSLOT));

  // Address decode; unmapped reads give zero
  always_comb
  begin
    rd_c = 32'h0;
    unique case (avs_address_i)
      `PBTS_A_CTRL: rd_c = {30'h0, s_q.hsel};
      `PBTS_A_BIND: rd_c = 32'(s_q.bind_en);
      `PBTS_A_TMEM: rd_c = {22'h0, s_q.members[9:0]};
      `PBTS_A_TTYPE: rd_c = {29'h0, s_q.neg};
      `PBTS_A_AGREE: rd_c = 32'(s_q.agree);
      `PBTS_A_LINK: rd_c = 32'(s_q.link);
      `PBTS_A_ACTIVE: rd_c = {19'h0, valid_c, act_c[2][1:0], act_c[1], act_c[0]};
      `PBTS_A_DROP: rd_c = 32'(s_q.drop_cnt);
      `PBTS_A_MSEL: rd_c = {22'h0, s_q.sel_slot, 3'h0, s_q.sel_port};
      `PBTS_A_MLO:
        if (sel_ok_c)
        begin
          rd_c = s_q.mac[sel_idx_c][31:0];
        end
      `PBTS_A_MHI:
        if (sel_ok_c)
        begin
          rd_c = {15'h0, s_q.mac[sel_idx_c][48:32]};
        end
      default: rd_c = 32'h0;
    endcase
  end
  assign m_c = pbts_merge(rd_c, avs_writedata_i, avs_byteenable_i);

  ////////////////////////////////////////////////////////////////////
  // Source binding check
  assign src_ok_c = fr_src_port_i < 5'(`PBTS_NPORT);
  assign src_idx_c = 7'(fr_src_port_i) * 7'(`PBTS_NSLOT);

  // One comparator per slot of the ingress port
  for (genvar g = 0; g < `PBTS_NSLOT; g++)
  begin : g_slot
    assign match_c[g] = src_ok_c &&
      s_q.mac[src_idx_c + 7'(g)][`PBTS_MAC_W] &&
      (s_q.mac[src_idx_c + 7'(g)][`PBTS_MAC_W-1:0] == fr_sa_i);
  end
  assign bind_on_c = src_ok_c && s_q.bind_en[fr_src_port_i];
  // Disabled ports are never checked
  assign drop_c = bind_on_c && (match_c == 3'h0);

  ////////////////////////////////////////////////////////////////////
  // Trunk member selection
  pbts_hash u_hash (
    .sel_i(s_q.hsel),
    .port_i(fr_src_port_i),
    .sa_i(fr_sa_i),
    .da_i(fr_da_i),
    .hash_o(hash_c)
  );
  assign lnk_c = {2'h0, s_q.link};
  assign agr_c = {2'h0, s_q.agree};

  // Per group: validity, usable members, picked link
  for (genvar g = 0; g < `PBTS_GRP_N; g++)
  begin : g_grp
    localparam logic [4:0] B = (g == 0) ? `PBTS_G0_BASE :
                               (g == 1) ? `PBTS_G1_BASE : `PBTS_G2_BASE;
    logic [3:0] gm; // Configured members of this group
    logic [4:0] off; // Destination offset inside group
    assign gm = s_q.members[g*`PBTS_GRP_W +: `PBTS_GRP_W];
    assign off = fr_dst_port_i - B;
    // Fewer than two members voids the group
    assign valid_c[g] = ($countones(gm) >= `PBTS_MIN_MEMBERS);
    assign inr_c[g] = (fr_dst_port_i >= B) && (off < 5'(`PBTS_GRP_W)) &&
                      gm[off[1:0]];
    assign hit_c[g] = inr_c[g] && valid_c[g];
    // Static uses every live member; negotiated needs agreement
    assign act_c[g] = valid_c[g] ?
      (gm & lnk_c[B +: 4] &
       (s_q.neg[g] ? agr_c[B +: 4] : 4'hf)) : 4'h0;
    assign pk_c[g] = B + 5'(pbts_pick(act_c[g], hash_c));
  end

  // Replace destination by picked member when a group owns it
  always_comb
  begin
    egress_c = fr_dst_port_i;
    trunk_c = 1'b0;
    for (int g = 0; g < `PBTS_GRP_N; g++)
    begin
      if (hit_c[g] && (act_c[g] != 4'h0))
      begin
        egress_c = pk_c[g];
        trunk_c = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    s_d = s_q;
    // Three stage link sync; change taken when stages 2 and 3 agree
    s_d.sync1 = link_up_i;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;
    s_d.link = (s_q.sync2 & s_q.sync3) |
               (s_q.link & (s_q.sync2 | s_q.sync3));
    // One wait cycle, then the answer edge
    s_d.wait_r = !(req_c && s_q.wait_r);
    if (req_c && s_q.wait_r)
    begin
      s_d.rdata = rd_c;
    end
    // Writes land at the edge where waitrequest is low
    if (avs_write_i && !s_q.wait_r)
    begin
      unique case (avs_address_i)
        `PBTS_A_CTRL: s_d.hsel = pbts_pkg::pbts_hash_t'(m_c[1:0]);
        `PBTS_A_BIND: s_d.bind_en = m_c[`PBTS_NPORT-1:0];
        `PBTS_A_TMEM: s_d.members = {2'h0, m_c[9:0]};
        `PBTS_A_TTYPE: s_d.neg = m_c[2:0];
        `PBTS_A_AGREE: s_d.agree = m_c[`PBTS_NPORT-1:0];
        `PBTS_A_MSEL:
        begin
          s_d.sel_port = m_c[4:0];
          s_d.sel_slot = m_c[`PBTS_SLOT_LSB +: 2];
        end
        `PBTS_A_MLO:
          if (sel_ok_c)
          begin
            s_d.mac[sel_idx_c][31:0] = m_c;
          end
        `PBTS_A_MHI:
          if (sel_ok_c)
          begin
            s_d.mac[sel_idx_c][48:32] = m_c[`PBTS_VLD_BIT:0];
          end
        default:
        begin
        end
      endcase
    end
    // Saturating count of refused frames
    if (push_c && drop_c && (s_q.drop_cnt != `PBTS_DROP_MAX))
    begin
      s_d.drop_cnt = s_q.drop_cnt + 16'h1;
    end
  end

  // State register
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      s_q <= '0;
      s_q.wait_r <= `PBTS_RST_WAIT;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Output buffer
  assign push_c = fr_valid_i && fr_ready_o;
  pbts_buf2 #(
    .W(`PBTS_FW_W)
  ) u_buf (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(fr_valid_i),
    .in_ready_o(fr_ready_o),
    .in_data_i({drop_c, trunk_c, egress_c}),
    .out_valid_o(fw_valid_o),
    .out_ready_i(fw_ready_i),
    .out_data_o(fw_data)
  );
  assign fw_drop_o = fw_data[6];
  assign fw_trunk_o = fw_data[5];
  assign fw_egress_o = fw_data[4:0];
  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = s_q.wait_r;

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  AST_BUS_ACK: assert property (req_c && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
  AST_BIND_ADMIT: assert property (push_c && bind_on_c && (match_c != 3'h0) |-> !drop_c)
    else $error("bound source dropped");
  AST_DROP_OUT: assert property (push_c && !fw_valid_o |=> fw_valid_o && fw_drop_o == $past(drop_c))
    else $error("drop flag lost");
  AST_MAC_STORE: assert property (avs_write_i && !avs_waitrequest_o
    && avs_address_i == `PBTS_A_MLO && avs_byteenable_i == 4'hf && sel_ok_c
    |=> s_q.mac[$past(sel_idx_c)][31:0] == $past(avs_writedata_i))
    else $error("address slot not written");
  AST_PER_PORT: assert property (push_c && drop_c |-> s_q.bind_en[fr_src_port_i])
    else $error("drop on unbound port");
  AST_HASH_DET: assert property (push_c && $past(push_c) && $stable(fr_sa_i)
    && $stable(fr_da_i) && $stable(fr_src_port_i) && $stable(fr_dst_port_i)
    && $stable(s_q.link) && $stable(s_q.neg)
    && $stable(s_q.agree) && $stable(s_q.hsel) && $stable(s_q.members)
    |-> $stable(egress_c))
    else $error("hash not deterministic");
  AST_HASH_SEL: assert property (push_c && trunk_c
    && s_q.hsel == pbts_pkg::PBTS_HASH_PORT
    && $past(push_c) && $stable(fr_src_port_i) && $stable(fr_dst_port_i) && $stable(s_q.neg)
    && $stable(s_q.link) && $stable(s_q.hsel) && $stable(s_q.agree) && $stable(s_q.members)
    |-> $stable(egress_c))
    else $error("port hash uses other fields");
  AST_LINK_UP: assert property (push_c && trunk_c |-> s_q.link[egress_c])
    else $error("trunk uses a down link");
  AST_GRP0: assert property (push_c && trunk_c && hit_c[0] |-> egress_c < `PBTS_G1_BASE)
    else $error("group zero out of range");
  AST_GRP1: assert property (push_c && trunk_c && hit_c[1]
    |-> egress_c >= `PBTS_G1_BASE && egress_c < `PBTS_G1_BASE + 5'(`PBTS_GRP_W))
    else $error("group one out of range");
  AST_GRP2: assert property (push_c && trunk_c && hit_c[2] |-> egress_c >= `PBTS_G2_BASE)
    else $error("group two out of range");
  AST_ONE_MEMBER: assert property (push_c && inr_c[0]
    && $countones(s_q.members[3:0]) < `PBTS_MIN_MEMBERS
    |-> !trunk_c && egress_c == fr_dst_port_i)
    else $error("single member group used");
  AST_STATIC: assert property (push_c && hit_c[0] && !s_q.neg[0]
    && (s_q.members[3:0] & s_q.link[3:0]) != 4'h0 |-> trunk_c)
    else $error("static group not aggregated");
  AST_NEG: assert property (push_c && trunk_c && (hit_c & s_q.neg) != 3'h0
    |-> s_q.agree[egress_c])
    else $error("member used before agreement");
  AST_NO_CHECK: assert property (push_c && !bind_on_c |-> !drop_c)
    else $error("check on disabled port");

  COV_DROP: cover property (push_c && drop_c);
  COV_TRUNK: cover property (push_c && trunk_c ##1 push_c && trunk_c);
  COV_STALL: cover property (fw_valid_o && !fw_ready_i && !fr_ready_o);
  COV_MAC_RD: cover property (avs_read_i && avs_address_i == `PBTS_A_MLO && !avs_waitrequest_o);
endmodule
`default_nettype wire

// ### pbts_fw_sink.sv
`timescale 1ns/100ps
`default_nettype none
// Receiver of forwarding results; it can stall
module pbts_fw_sink (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic stall_i,
  input wire logic fw_valid_i,
  input wire logic [6:0] fw_res_i,
  output logic fw_ready_o
);
  // Results taken, oldest first
  logic [6:0] got_q[$];
  //////////////////////////////////////////////////////////////
  // Ready follows stall one edge late; take on handshake
  always @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      fw_ready_o <= 1'b0;
      got_q.delete();
    end
    else
    begin
      if (fw_valid_i && fw_ready_o)
      begin
        got_q.push_back(fw_res_i);
      end
      fw_ready_o <= !stall_i;
    end
  end
endmodule
`default_nettype wire

// ### testbench.sv
`timescale 1ns/100ps
`default_nettype none
`include "pbts_defines.svh"
module testbench;
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [5:0] adr = 6'h00;
  logic rd = 1'b0, wr = 1'b0, wreq, fv = 1'b0, frdy, fwv, fwr, stall = 1'b0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [25:0] link = 26'h3ffffff;
  logic [4:0] fsrc = 5'h0, fdst = 5'h0;
  logic [47:0] fsa = 48'h0, fda = 48'h0;
  logic fdrop, ftrk;
  logic [4:0] fegr;
  int err_count = 0, n_checks = 0, cyc = 0;
  //////////////////////////////////////////////////////////////
  // Clock of 50 ns
  always #25 clk_sys_i = ~clk_sys_i;
  pbts_top i_pbts_top (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq), .link_up_i(link), .fr_valid_i(fv),
    .fr_ready_o(frdy), .fr_src_port_i(fsrc), .fr_dst_port_i(fdst),
    .fr_sa_i(fsa), .fr_da_i(fda), .fw_valid_o(fwv), .fw_ready_i(fwr),
    .fw_drop_o(fdrop), .fw_trunk_o(ftrk), .fw_egress_o(fegr));
  pbts_fw_sink i_pbts_fw_sink (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
    .stall_i(stall), .fw_valid_i(fwv), .fw_res_i({fdrop, ftrk, fegr}),
    .fw_ready_o(fwr));
  //////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // One Avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    adr <= a;
    wdat <= d;
    rd <= !w;
    wr <= w;
    do @(posedge clk_sys_i); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e, "register read");
  endtask
  // Take the next result from the receiver, bounded wait
  task automatic pop(output logic [6:0] r);
    int n;
    n = 0;
    while (i_pbts_fw_sink.got_q.size() == 0 && n < 20)
    begin
      @(posedge clk_sys_i);
      n++;
    end
    r = (n < 20) ? i_pbts_fw_sink.got_q.pop_front() : 7'bx;
  endtask
  // One descriptor in, one result out
  task automatic xfer(input logic [4:0] s, input logic [4:0] d, input logic [47:0] sa,
                      input logic [47:0] da, output logic [6:0] r);
    fsrc <= s;
    fdst <= d;
    fsa <= sa;
    fda <= da;
    fv <= 1'b1;
    do @(posedge clk_sys_i); while (frdy !== 1'b1);
    fv <= 1'b0;
    pop(r);
  endtask
  // Byte fold of a hash key
  function automatic logic [7:0] hx(input logic [47:0] k);
    logic [7:0] h;
    h = 8'h00;
    for (int i = 0; i < 6; i++) h = h ^ k[8*i +: 8];
    return h;
  endfunction
  function automatic logic [47:0] mac(input int s);
    return 48'h02a0b0c0d000 + 48'(s);
  endfunction
  //////////////////////////////////////////////////////////////
  // Reset values, read-only and unmapped places
  task automatic t_regs;
    rchk(`PBTS_A_CTRL, 32'h0);
    rchk(`PBTS_A_BIND, 32'h0);
    rchk(`PBTS_A_LINK, 32'h3ffffff);
    wreg(`PBTS_A_DROP, 32'h5);
    rchk(`PBTS_A_DROP, 32'h0);
    wreg(6'h3c, 32'h7);
    rchk(6'h3c, 32'h0);
    $display("test regs done");
  endtask
  // Three address slots of one port, plus a slot out of range
  task automatic t_mac;
    logic [47:0] m;
    for (int s = 0; s < 3; s++)
    begin
      m = mac(s);
      wreg(`PBTS_A_MSEL, 32'(s << 8) | 32'h2);
      wreg(`PBTS_A_MLO, m[31:0]);
      wreg(`PBTS_A_MHI, {15'h0, 1'b1, m[47:32]});
    end
    for (int s = 0; s < 3; s++)
    begin
      m = mac(s);
      wreg(`PBTS_A_MSEL, 32'(s << 8) | 32'h2);
      rchk(`PBTS_A_MLO, m[31:0]);
      rchk(`PBTS_A_MHI, {15'h0, 1'b1, m[47:32]});
    end
    wreg(`PBTS_A_MSEL, 32'h302);
    rchk(`PBTS_A_MLO, 32'h0);
    $display("test mac done");
  endtask
  // Source binding on port index 2 only
  task automatic t_bind;
    logic [6:0] r;
    wreg(`PBTS_A_BIND, 32'h4);
    for (int s = 0; s < 3; s++)
    begin
      xfer(5'd2, 5'd10, mac(s), 48'h1, r);
      chk(r, {2'b00, 5'd10}, "bound source");
    end
    xfer(5'd2, 5'd10, 48'h02a0b0c0d099, 48'h1, r);
    chk(r, {2'b10, 5'd10}, "unbound source");
    xfer(5'd3, 5'd10, 48'h02a0b0c0d099, 48'h1, r);
    chk(r, {2'b00, 5'd10}, "binding off");
    rchk(`PBTS_A_DROP, 32'h1);
    $display("test bind done");
  endtask
  // Four hash inputs on a static group of ports zero and one
  task automatic t_hash;
    logic [6:0] r, r2;
    logic [47:0] k;
    logic [7:0] h;
    wreg(`PBTS_A_TMEM, 32'h3);
    for (int m = 0; m < 4; m++)
    begin
      wreg(`PBTS_A_CTRL, 32'(m));
      xfer(5'd9, 5'd0, 48'h1, 48'h2, r);
      xfer(5'd9, 5'd1, 48'h1, 48'h2, r2);
      chk(r2, r, "same key");
      // Key: ingress port nine, source one, destination two, or both folded
      k = (m == 0) ? 48'h9 : (m == 1) ? 48'h1 : (m == 2) ? 48'h2 : 48'h3;
      h = hx(k);
      if (m == 0)
        chk(r, {2'b01, 4'h0, h[0]}, "port hash");
      else
        chk(r, {2'b01, 4'h0, h[0]}, "mac hash");
      // Same descriptor twice, back to back
      fv <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      fv <= 1'b0;
      for (int j = 0; j < 2; j++)
      begin
        pop(r2);
        chk(r2, r, "back to back");
      end
    end
    $display("test hash done");
  endtask
  // Group of ports four to seven losing and regaining a link
  task automatic t_fail;
    logic [6:0] r;
    wreg(`PBTS_A_TMEM, 32'hf0);
    wreg(`PBTS_A_CTRL, 32'h1);
    xfer(5'd9, 5'd5, 48'h6, 48'h0, r);
    chk(r, {2'b01, 5'd6}, "all up");
    xfer(5'd9, 5'd8, 48'h6, 48'h0, r);
    chk(r, {2'b00, 5'd8}, "outside group");
    link <= 26'h3ffffbf;
    repeat (6) @(posedge clk_sys_i);
    xfer(5'd9, 5'd5, 48'h6, 48'h0, r);
    chk(r, {2'b01, 5'd4}, "member down");
    link <= 26'h3ffffff;
    repeat (6) @(posedge clk_sys_i);
    xfer(5'd9, 5'd5, 48'h6, 48'h0, r);
    chk(r, {2'b01, 5'd6}, "member back");
    $display("test fail done");
  endtask
  // Gigabit group, single-member groups, negotiated group
  task automatic t_grp;
    logic [6:0] r;
    wreg(`PBTS_A_TMEM, 32'h300);
    xfer(5'd9, 5'd24, 48'h1, 48'h0, r);
    chk(r, {2'b01, 5'd25}, "gigabit group");
    wreg(`PBTS_A_TMEM, 32'h101);
    xfer(5'd9, 5'd24, 48'h1, 48'h0, r);
    chk(r, {2'b00, 5'd24}, "single member");
    xfer(5'd9, 5'd0, 48'h1, 48'h0, r);
    chk(r, {2'b00, 5'd0}, "single member");
    wreg(`PBTS_A_TMEM, 32'h3);
    wreg(`PBTS_A_TTYPE, 32'h1);
    xfer(5'd9, 5'd0, 48'h1, 48'h0, r);
    chk(r, {2'b00, 5'd0}, "no agreement");
    wreg(`PBTS_A_AGREE, 32'h3);
    xfer(5'd9, 5'd0, 48'h1, 48'h0, r);
    chk(r, {2'b01, 5'd1}, "agreed");
    wreg(`PBTS_A_TTYPE, 32'h0);
    $display("test groups done");
  endtask
  // Receiver stalls: two results held, third refused, order kept
  task automatic t_buf;
    logic [6:0] r;
    int n;
    wreg(`PBTS_A_TMEM, 32'h0);
    stall <= 1'b1;
    fsrc <= 5'd20;
    for (int i = 0; i < 3; i++)
    begin
      fdst <= 5'(11 + i);
      fv <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clk_sys_i);
        n++;
      end
      while (frdy !== 1'b1 && n < 12);
    end
    chk(n, 12, "third refused");
    stall <= 1'b0;
    do @(posedge clk_sys_i); while (frdy !== 1'b1);
    fv <= 1'b0;
    for (int i = 0; i < 3; i++)
    begin
      pop(r);
      chk(r, {2'b00, 5'(11 + i)}, "order kept");
    end
    $display("test buffer done");
  endtask
  //////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_sys_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      close_out;
    end
  end
  // Main sequence
  initial
  begin
    repeat (10) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    repeat (5) @(posedge clk_sys_i);
    t_regs;
    t_mac;
    t_bind;
    t_hash;
    t_fail;
    t_grp;
    t_buf;
    close_out;
  end
endmodule
`default_nettype wire
